// ==== common/icpb_pkg.sv ====
/*
  Shared constants and carrier types for the indexed configuration port bank:
  global offsets, per-device bank geometry, keys, reset values and the request
  structs used by the host I/O port and the embedded-controller direct port.
  Assumes a single clock and one-cycle request strobes from both requesters.
*/
`default_nettype none
package icpb_pkg;

  // geometry
  localparam int NUM_LD    = 4;                      // logical devices implemented
  localparam int LD_IDX_W  = 2;                      // bits to index them
  localparam int BANK_REGS = 208;                    // per-device registers, 30h..FFh

  // keys written to the index port
  localparam logic [7:0] KEY_ENTRY = 8'h55;
  localparam logic [7:0] KEY_EXIT  = 8'hAA;

  // global offsets
  localparam logic [7:0] GOFF_RSVD0_LO = 8'h00;
  localparam logic [7:0] GOFF_RSVD0_HI = 8'h01;
  localparam logic [7:0] GOFF_TEST_A   = 8'h02;
  localparam logic [7:0] GOFF_RSVD1_LO = 8'h03;
  localparam logic [7:0] GOFF_RSVD1_HI = 8'h06;
  localparam logic [7:0] GOFF_LDN      = 8'h07;
  localparam logic [7:0] GOFF_RSVD2_LO = 8'h08;
  localparam logic [7:0] GOFF_RSVD2_HI = 8'h18;
  localparam logic [7:0] GOFF_REV      = 8'h1C;
  localparam logic [7:0] GOFF_SUBID    = 8'h1D;
  localparam logic [7:0] GOFF_DEVID_LO = 8'h1E;
  localparam logic [7:0] GOFF_DEVID_HI = 8'h1F;
  localparam logic [7:0] GOFF_LEGACY   = 8'h20;
  localparam logic [7:0] GOFF_TEST_B0  = 8'h22;
  localparam logic [7:0] GOFF_TEST_B1  = 8'h23;
  localparam logic [7:0] GOFF_OTP      = 8'h24;
  localparam logic [7:0] GOFF_VALID    = 8'h25;
  localparam logic [7:0] GOFF_BOOT_LO  = 8'h26;
  localparam logic [7:0] GOFF_BOOT_HI  = 8'h27;
  localparam logic [7:0] GOFF_TEST_C_LO = 8'h28;
  localparam logic [7:0] GOFF_TEST_C_HI = 8'h2F;
  localparam logic [7:0] LD_BASE       = 8'h30;      // first per-device offset
  localparam logic [7:0] LDN_GLOBAL    = 8'h3F;      // device number naming the globals

  // per-device fields
  localparam logic [7:0] LOFF_ACTIVATE = 8'h30;      // bit 0 activates the device
  localparam int         ACT_BIT       = 0;
  localparam logic [7:0] LD_PORT       = 8'h03;      // device owning the port base
  localparam logic [7:0] LOFF_BASE_LO  = 8'h34;
  localparam logic [7:0] LOFF_BASE_HI  = 8'h35;

  // reset values and read answers
  localparam logic [15:0] PORT_BASE_RST = 16'h002E;
  localparam logic [7:0]  INDEX_RST     = 8'h00;
  localparam logic [7:0]  RD_UNDEF      = 8'hFF;
  localparam logic [7:0]  RD_RSVD       = 8'h00;
  localparam logic [15:0] PORT_DATA_OFS = 16'h0001;
  localparam logic [7:0]  EC_BASE_HI    = 8'h10;     // ec address page of the bank

  // identification defaults, values arbitrary
  localparam logic [7:0]  REV_DEF    = 8'h01;
  localparam logic [7:0]  SUBID_DEF  = 8'h02;
  localparam logic [15:0] DEVID_DEF  = 16'h1234;
  localparam logic [7:0]  LEGACY_DEF = 8'h5A;
  localparam logic [7:0]  OTP_DEF    = 8'h03;
  localparam logic [7:0]  VALID_DEF  = 8'h04;
  localparam logic [15:0] BOOT_DEF   = 16'h0105;

  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } icpb_req_t;

  typedef struct packed {
    logic                                  cfg_mode;
    logic [7:0]                            index;
    logic [7:0]                            ldn;
    logic [15:0]                           port_base;
    logic [7:0]                            test_a;
    logic [15:0]                           test_b;
    logic [63:0]                           test_c;
    logic [NUM_LD-1:0][BANK_REGS-1:0][7:0] bank;
    logic                                  io_ack;
    logic [7:0]                            io_rdata;
    logic                                  ec_ack;
    logic [7:0]                            ec_rdata;
  } icpb_state_t;

  localparam icpb_state_t STATE_RST = '{port_base: PORT_BASE_RST, default: '0};

endpackage
`default_nettype wire

// ==== hdl/icpb_bank.sv ====
/*
  Indexed configuration register bank: host index/data port pair, key-gated
  configuration state, global identification registers and per-device banks,
  plus a direct embedded-controller port at a fixed address page.
  Assumes requests are one-cycle strobes synchronous to clk; every request is
  answered by an ack pulse one cycle later with read data beside it.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// RULE1: host enters configuration state, programs registers, then leaves it.
// RULE2: host writes 55h to index port to enter, AAh to leave.
// RULE3: an index write of AAh in configuration state ends that state.
// RULE4: forty-eight eight-bit global registers live at offsets 00h to 2Fh.
// RULE5: each logical device owns its own bank of up to 208 registers.
// RULE6: global 07h holds the selected device number steering bank accesses.
// RULE7: host selects a device via 07h, then indexes its register through data.
// RULE8: global registers are served whatever device number is selected.
// RULE9: writes to undefined or reserved places complete and change nothing.
// RULE10: reads of undefined places return FFh.
// RULE11: globals are reached through the port pair as device 3Fh.
// RULE12: controller reaches registers directly at base plus offset.
// RULE13: offsets up to 2Fh stay reachable whichever device is selected.
// RULE14: reserved 00h-01h, 03h-06h, 08h-18h ignore writes and read zero.
// RULE15: activation acts only on the currently selected logical device.
// RULE16: sixteen-bit identifier is read-only, low at 1Eh, high at 1Fh.
// RULE17: read-only revision at 1Ch and sub-identifier at 1Dh.
// RULE18: read-only fixed legacy identification byte at 20h.
// RULE19: read-only otp_identifier 24h, validation_identifier 25h, boot revision 26h-27h.
// RULE20: host must leave vendor test places 02h, 22h-23h, 28h-2Fh alone.
// RULE21: index and data ports act only in configuration state.
// RULE22: power-on or host reset returns configuration state to disabled.
// RULE23: index at port base, data at base plus one, default 2Eh/2Fh.
// RULE24: device banks appear at 30h to FFh, chosen by 07h.
module icpb_bank #(
  parameter logic [7:0]  REV_ID    = icpb_pkg::REV_DEF,    // value arbitrary
  parameter logic [7:0]  SUB_ID    = icpb_pkg::SUBID_DEF,  // value arbitrary
  parameter logic [15:0] DEV_ID    = icpb_pkg::DEVID_DEF,  // value arbitrary
  parameter logic [7:0]  LEGACY_ID = icpb_pkg::LEGACY_DEF, // value arbitrary
  parameter logic [7:0]  OTP_IDENTIFIER    = icpb_pkg::OTP_DEF,    // value arbitrary
  parameter logic [7:0]  VALID_ID  = icpb_pkg::VALID_DEF,  // value arbitrary
  parameter logic [15:0] BOOT_REV  = icpb_pkg::BOOT_DEF    // value arbitrary
) (
  input  wire logic                             clk,        // system clock, 125 MHz
  input  wire logic                             rst_b,      // power_on_reset, async low
  input  wire logic                             host_reset, // host reset level, high
  input  wire icpb_pkg::icpb_req_t              io,         // host i/o cycle
  output logic                                  io_ack,     // host answer pulse
  output logic [7:0]                            io_rdata,   // host read byte
  input  wire icpb_pkg::icpb_req_t              ec,         // controller direct access
  output logic                                  ec_ack,     // controller answer pulse
  output logic [7:0]                            ec_rdata,   // controller read byte
  output logic                                  cfg_mode,   // configuration state
  output logic [7:0]                            sel_ldn,    // selected device number
  output logic [15:0]                           port_base,  // index port i/o address
  output logic [icpb_pkg::NUM_LD-1:0]           dev_active  // per-device activate bits
);

  icpb_pkg::icpb_state_t state_reg;
  icpb_pkg::icpb_state_t state_next;

  // true when the held device number names an implemented bank
  function automatic logic ldn_valid(input logic [7:0] ldn);
    return ldn < 8'(icpb_pkg::NUM_LD);
  endfunction

  // true for offsets that are reserved-reads-zero
  function automatic logic is_rsvd(input logic [7:0] off);
    return (off <= icpb_pkg::GOFF_RSVD0_HI) ||                                    // RULE14
           (off >= icpb_pkg::GOFF_RSVD1_LO && off <= icpb_pkg::GOFF_RSVD1_HI) ||
           (off >= icpb_pkg::GOFF_RSVD2_LO && off <= icpb_pkg::GOFF_RSVD2_HI);
  endfunction

  // read decode shared by the host data port and the controller port
  function automatic logic [7:0] rd_cfg(input icpb_pkg::icpb_state_t s,
                                        input logic [7:0]             off);
    logic [7:0] d;
    logic [7:0] bi;
    d  = icpb_pkg::RD_UNDEF;                                                       // RULE10
    bi = off - icpb_pkg::LD_BASE;
    // globals below 30h never look at the device number
    if (is_rsvd(off)) begin                                                        // RULE4
      d = icpb_pkg::RD_RSVD;                                                       // RULE14
    end else if (off == icpb_pkg::GOFF_TEST_A) begin
      d = s.test_a;
    end else if (off == icpb_pkg::GOFF_LDN) begin
      d = s.ldn;                                                                   // RULE6
    end else if (off == icpb_pkg::GOFF_REV) begin
      d = REV_ID;                                                                  // RULE17
    end else if (off == icpb_pkg::GOFF_SUBID) begin
      d = SUB_ID;                                                                  // RULE17
    end else if (off == icpb_pkg::GOFF_DEVID_LO) begin
      d = DEV_ID[7:0];                                                             // RULE16
    end else if (off == icpb_pkg::GOFF_DEVID_HI) begin
      d = DEV_ID[15:8];                                                            // RULE16
    end else if (off == icpb_pkg::GOFF_LEGACY) begin
      d = LEGACY_ID;                                                               // RULE18
    end else if (off == icpb_pkg::GOFF_TEST_B0) begin
      d = s.test_b[7:0];
    end else if (off == icpb_pkg::GOFF_TEST_B1) begin
      d = s.test_b[15:8];
    end else if (off == icpb_pkg::GOFF_OTP) begin
      d = OTP_IDENTIFIER;                                                                  // RULE19
    end else if (off == icpb_pkg::GOFF_VALID) begin
      d = VALID_ID;                                                                // RULE19
    end else if (off == icpb_pkg::GOFF_BOOT_LO) begin
      d = BOOT_REV[7:0];                                                           // RULE19
    end else if (off == icpb_pkg::GOFF_BOOT_HI) begin
      d = BOOT_REV[15:8];                                                          // RULE19
    end else if (off >= icpb_pkg::GOFF_TEST_C_LO && off <= icpb_pkg::GOFF_TEST_C_HI) begin
      d = s.test_c[off[2:0]*8 +: 8];
    end else if (off >= icpb_pkg::LD_BASE && ldn_valid(s.ldn)) begin              // RULE11
      // device 3Fh and unimplemented devices fall through to FFh
      if (s.ldn == icpb_pkg::LD_PORT && off == icpb_pkg::LOFF_BASE_LO) begin
        d = s.port_base[7:0];                                                      // RULE23
      end else if (s.ldn == icpb_pkg::LD_PORT && off == icpb_pkg::LOFF_BASE_HI) begin
        d = s.port_base[15:8];                                                     // RULE23
      end else begin
        d = s.bank[s.ldn[icpb_pkg::LD_IDX_W-1:0]][bi];                             // RULE24
      end
    end
    return d;
  endfunction

  // write decode shared by both requesters; read-only and reserved places drop
  function automatic icpb_pkg::icpb_state_t wr_cfg(input icpb_pkg::icpb_state_t s,
                                                   input logic [7:0]             off,
                                                   input logic [7:0]             d,
                                                   input logic [7:0]             sel);
    icpb_pkg::icpb_state_t r;
    logic [7:0]            bi;
    r  = s;
    bi = off - icpb_pkg::LD_BASE;
    if (off == icpb_pkg::GOFF_LDN) begin
      r.ldn = d;                                                                   // RULE6
    end else if (off == icpb_pkg::GOFF_TEST_A) begin
      r.test_a = d;
    end else if (off == icpb_pkg::GOFF_TEST_B0) begin
      r.test_b[7:0] = d;
    end else if (off == icpb_pkg::GOFF_TEST_B1) begin
      r.test_b[15:8] = d;
    end else if (off >= icpb_pkg::GOFF_TEST_C_LO && off <= icpb_pkg::GOFF_TEST_C_HI) begin
      r.test_c[off[2:0]*8 +: 8] = d;
    end else if (off >= icpb_pkg::LD_BASE && ldn_valid(sel)) begin
      // only the selected bank is touched, so activation cannot leak
      // sel is the pre-cycle number, so a same-cycle 07h write cannot steer the other port
      if (sel == icpb_pkg::LD_PORT && off == icpb_pkg::LOFF_BASE_LO) begin
        r.port_base[7:0] = d;                                                      // RULE23
      end else if (sel == icpb_pkg::LD_PORT && off == icpb_pkg::LOFF_BASE_HI) begin
        r.port_base[15:8] = d;                                                     // RULE23
      end else begin
        r.bank[sel[icpb_pkg::LD_IDX_W-1:0]][bi] = d;                               // RULE15
      end
    end
    // everything else (ids, reserved, undefined) leaves r equal to s
    return r;                                                                      // RULE9
  endfunction

  // next-state: host port first, controller second so it wins a same-byte clash
  always_comb begin
    logic io_idx;
    logic io_dat;
    logic ec_hit;
    state_next = state_reg;
    io_idx = io.req && (io.addr == state_reg.port_base);                          // RULE23
    io_dat = io.req && (io.addr == 16'(state_reg.port_base + icpb_pkg::PORT_DATA_OFS));
    ec_hit = ec.req && (ec.addr[15:8] == icpb_pkg::EC_BASE_HI);                   // RULE12
    state_next.io_ack = io.req;
    state_next.ec_ack = ec.req;
    if (io.req) begin
      state_next.io_rdata = icpb_pkg::RD_UNDEF;
    end
    if (ec.req) begin
      state_next.ec_rdata = icpb_pkg::RD_UNDEF;
    end
    // index port: keys outside configuration state, pointer inside it
    if (io_idx && io.wr) begin
      if (!state_reg.cfg_mode) begin
        if (io.wdata == icpb_pkg::KEY_ENTRY) begin
          state_next.cfg_mode = 1'b1;                                              // RULE21
        end
      end else if (io.wdata == icpb_pkg::KEY_EXIT) begin
        state_next.cfg_mode = 1'b0;                                                // RULE3
      end else begin
        state_next.index = io.wdata;
      end
    end else if (io_idx && state_reg.cfg_mode) begin
      state_next.io_rdata = state_reg.index;
    end
    // data port: only effective in configuration state
    if (io_dat && state_reg.cfg_mode) begin                                        // RULE21
      if (io.wr) begin
        state_next = wr_cfg(state_next, state_reg.index, io.wdata, state_reg.ldn); // RULE8
      end else begin
        state_next.io_rdata = rd_cfg(state_reg, state_reg.index);                  // RULE13
      end
    end
    // controller port ignores the configuration state and the index pointer
    if (ec_hit) begin
      if (ec.wr) begin
        state_next = wr_cfg(state_next, ec.addr[7:0], ec.wdata, state_reg.ldn);    // RULE12
      end else begin
        state_next.ec_rdata = rd_cfg(state_reg, ec.addr[7:0]);                     // RULE12
      end
    end
    // host reset overrides any key seen in the same cycle
    if (host_reset) begin
      state_next.cfg_mode = 1'b0;                                                  // RULE22
      state_next.index    = icpb_pkg::INDEX_RST;
    end
  end

  // single state register; power-on reset clears the configuration state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= icpb_pkg::STATE_RST;                                            // RULE22
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign io_ack    = state_reg.io_ack;
  assign io_rdata  = state_reg.io_rdata;
  assign ec_ack    = state_reg.ec_ack;
  assign ec_rdata  = state_reg.ec_rdata;
  assign cfg_mode  = state_reg.cfg_mode;
  assign sel_ldn   = state_reg.ldn;
  assign port_base = state_reg.port_base;

  genvar gi;
  generate
    for (gi = 0; gi < icpb_pkg::NUM_LD; gi++) begin : g_act
      assign dev_active[gi] = state_reg.bank[gi][0][icpb_pkg::ACT_BIT];           // RULE5
    end
  endgenerate

  // helper views for the checks below
  logic                        idx_wr;
  logic                        dat_rd;
  logic                        dat_wr;
  logic [icpb_pkg::NUM_LD-1:0] sel_mask;
  logic                        dat_hit;
  assign idx_wr   = io.req && io.wr && (io.addr == state_reg.port_base);
  assign dat_rd   = io.req && !io.wr && state_reg.cfg_mode && !ec.req &&
                    (io.addr == 16'(state_reg.port_base + icpb_pkg::PORT_DATA_OFS));
  assign dat_wr   = io.req && io.wr && state_reg.cfg_mode && !ec.req &&
                    (io.addr == 16'(state_reg.port_base + icpb_pkg::PORT_DATA_OFS));
  assign sel_mask = ldn_valid(state_reg.ldn) ?
                    icpb_pkg::NUM_LD'(1) << state_reg.ldn[icpb_pkg::LD_IDX_W-1:0] : '0;
  assign dat_hit  = io.req && !ec.req &&
                    (io.addr == 16'(state_reg.port_base + icpb_pkg::PORT_DATA_OFS));

  a_exit_key_clears: assert property (@(posedge clk) disable iff (!rst_b)  // RULE3
    idx_wr && state_reg.cfg_mode && io.wdata == 8'hAA |=> !cfg_mode)
    else $error("exit key did not end configuration state");

  a_entry_key_sets: assert property (@(posedge clk) disable iff (!rst_b)  // RULE21
    idx_wr && !state_reg.cfg_mode && !host_reset && io.wdata == 8'h55 |=> cfg_mode)
    else $error("entry key did not start configuration state");

  a_host_reset_exit: assert property (@(posedge clk) disable iff (!rst_b)  // RULE22
    host_reset |=> !cfg_mode && state_reg.index == 8'h00)
    else $error("host reset left configuration state on");

  a_io_ack_timing: assert property (@(posedge clk) disable iff (!rst_b)  // RULE9
    io.req |=> io_ack ##1 (!io_ack || $past(io.req)))
    else $error("host request not answered in one cycle");

  a_rsvd_read_zero: assert property (@(posedge clk) disable iff (!rst_b)  // RULE14
    dat_rd && is_rsvd(state_reg.index) |=> io_rdata == 8'h00)
    else $error("reserved global did not read zero");

  a_undef_read_ff: assert property (@(posedge clk) disable iff (!rst_b)  // RULE10
    dat_rd && state_reg.index >= 8'h30 && state_reg.ldn >= 8'h04 |=> io_rdata == 8'hFF)
    else $error("undefined location did not read FFh");

  a_devid_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE16
    dat_rd && state_reg.index == 8'h1E |=> io_rdata == DEV_ID[7:0])
    else $error("identifier low byte wrong");

  a_ldn_written: assert property (@(posedge clk) disable iff (!rst_b)  // RULE6
    dat_wr && state_reg.index == 8'h07 |=> sel_ldn == $past(io.wdata))
    else $error("device number not taken from data port");

  a_act_selected: assert property (@(posedge clk) disable iff (!rst_b)  // RULE15
    1'b1 |=> ((dev_active ^ $past(dev_active)) & ~$past(sel_mask)) == '0)
    else $error("activation changed an unselected device");

  a_ec_devid_hi: assert property (@(posedge clk) disable iff (!rst_b)  // RULE12
    ec.req && !ec.wr && ec.addr == {icpb_pkg::EC_BASE_HI, 8'h1F}
      |=> ec_ack && ec_rdata == DEV_ID[15:8])
    else $error("controller direct read of identifier wrong");

  a_ro_unchanged: assert property (@(posedge clk) disable iff (!rst_b)  // RULE9
    dat_wr && state_reg.index == 8'h1C |=> $stable(state_reg.test_c) && $stable(sel_ldn))
    else $error("write to read-only place changed state");

  // identity answers, port gating, controller ack and port base move, each looked at one cycle after the strobe
  a_data_wr_gated: assert property (@(posedge clk) disable iff (!rst_b)  // RULE21
    dat_hit && io.wr && !state_reg.cfg_mode |=> $stable(sel_ldn) && $stable(dev_active))
    else $error("data port write acted outside configuration state");

  a_data_rd_gated: assert property (@(posedge clk) disable iff (!rst_b)  // RULE21
    dat_hit && !io.wr && !state_reg.cfg_mode |=> io_rdata == 8'hFF)
    else $error("data port read answered outside configuration state");

  a_index_readback: assert property (@(posedge clk) disable iff (!rst_b)  // RULE21
    io.req && !io.wr && state_reg.cfg_mode && io.addr == state_reg.port_base
      |=> io_rdata == $past(state_reg.index))
    else $error("index port read did not return the pointer");

  a_rev_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE17
    dat_rd && state_reg.index == 8'h1C |=> io_rdata == REV_ID)
    else $error("revision read wrong");

  a_subid_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE17
    dat_rd && state_reg.index == 8'h1D |=> io_rdata == SUB_ID)
    else $error("sub-identifier read wrong");

  a_devid_hi_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE16
    dat_rd && state_reg.index == 8'h1F |=> io_rdata == DEV_ID[15:8])
    else $error("identifier high byte wrong");

  a_legacy_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE18
    dat_rd && state_reg.index == 8'h20 |=> io_rdata == LEGACY_ID)
    else $error("legacy identifier read wrong");

  a_otp_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE19
    dat_rd && state_reg.index == 8'h24 |=> io_rdata == OTP_IDENTIFIER)
    else $error("otp identifier read wrong");

  a_boot_read: assert property (@(posedge clk) disable iff (!rst_b)  // RULE19
    dat_rd && state_reg.index == 8'h26 |=> io_rdata == BOOT_REV[7:0])
    else $error("boot revision low byte wrong");

  a_ec_ack_timing: assert property (@(posedge clk) disable iff (!rst_b)  // RULE12
    ec.req |=> ec_ack)
    else $error("controller request not answered in one cycle");

  a_port_base_move: assert property (@(posedge clk) disable iff (!rst_b)  // RULE23
    dat_wr && state_reg.ldn == 8'h03 && state_reg.index == 8'h34
      |=> port_base[7:0] == $past(io.wdata))
    else $error("port base low byte not taken");

endmodule
`default_nettype wire

// ==== tb/icpb_host.sv ====
/*
  Host-side model: issues one-byte i/o cycles to the bank and returns ack plus read byte.
  Assumes the bank answers at the edge that takes the request, one cycle after it was driven.
*/
`timescale 1ns/10ps
`default_nettype none
module icpb_host (
  input  wire logic                 clk,   // system clock
  output var  icpb_pkg::icpb_req_t  rq,    // request to the bank
  input  wire logic                 ack,   // answer pulse
  input  wire logic [7:0]           rdata  // answer byte
);
  initial rq = '0;
  // request stands one edge; released lines are inverted so stale values never pass
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [8:0] r);
    @(posedge clk);
    rq <= '{req: 1'h1, wr: wr, addr: a, wdata: d};
    @(posedge clk);
    rq <= '{req: 1'h0, wr: ~wr, addr: ~a, wdata: ~d};
    #1;
    r = {ack, rdata};
  endtask
  // keys go to the index address only; entry, program, exit order is the caller's
  task automatic key(input logic [15:0] base, input logic [7:0] k, output logic [8:0] r);
    xfer(1'h1, base, k, r);
  endtask
  // index first, then the data port; test places are never written by this model
  task automatic idx_data(input logic [15:0] base, input logic [7:0] off, input logic wr,
                          input logic [7:0] d, output logic [8:0] r);
    xfer(1'h1, base, off, r);
    xfer(wr, base + 16'h0001, d, r);
  endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the configuration bank: host port sequences and direct access.
  Assumes the bank's default identity parameters and a 125 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic                        clk, rst_b, host_reset, io_ack, ec_ack, cfg_mode;
  icpb_pkg::icpb_req_t         io, ec;
  logic [7:0]                  io_rdata, ec_rdata, sel_ldn;
  logic [15:0]                 port_base, pb;
  logic [icpb_pkg::NUM_LD-1:0] dev_active;
  logic [8:0]                  r;
  int                          n_mismatch, tests_run;
  // global offsets and their expected answers: ids, reserved zeros, undefined
  logic [7:0] t_off [18] = '{8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h24, 8'h25, 8'h26, 8'h27,
                             8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h18, 8'h19, 8'h1B, 8'h21};
  logic [7:0] t_exp [18] = '{icpb_pkg::REV_DEF, icpb_pkg::SUBID_DEF, icpb_pkg::DEVID_DEF[7:0],
                             icpb_pkg::DEVID_DEF[15:8], icpb_pkg::LEGACY_DEF, icpb_pkg::OTP_DEF,
                             icpb_pkg::VALID_DEF, icpb_pkg::BOOT_DEF[7:0],
                             icpb_pkg::BOOT_DEF[15:8], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'hFF, 8'hFF, 8'hFF};

  icpb_bank i_dut (.clk(clk), .rst_b(rst_b), .host_reset(host_reset), .io(io),
                   .io_ack(io_ack), .io_rdata(io_rdata), .ec(ec), .ec_ack(ec_ack),
                   .ec_rdata(ec_rdata), .cfg_mode(cfg_mode), .sel_ldn(sel_ldn),
                   .port_base(port_base), .dev_active(dev_active));
  icpb_host i_host (.clk(clk), .rq(io), .ack(io_ack), .rdata(io_rdata));
  icpb_host i_ec (.clk(clk), .rq(ec), .ack(ec_ack), .rdata(ec_rdata));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cw(input logic [7:0] off, input logic [7:0] d);
    i_host.idx_data(pb, off, 1'h1, d, r);
    chk(16'(r[8]), 16'h0001);
  endtask
  task automatic cr(input logic [7:0] off, input logic [7:0] exp);
    i_host.idx_data(pb, off, 1'h0, 8'h00, r);
    chk(16'(r), {7'h00, 1'h1, exp});
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watchdog: whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    rst_b = 1'h0;
    host_reset = 1'h0;
    n_mismatch = 0;
    tests_run = 0;
    pb = icpb_pkg::PORT_BASE_RST;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    chk(port_base, 16'h002E);
    i_host.xfer(1'h0, pb + 16'h0001, 8'h00, r);
    chk(16'(r), 16'h01FF);
    cw(icpb_pkg::GOFF_LDN, 8'h02);
    chk(16'(sel_ldn), 16'h0000);
    i_host.key(pb, icpb_pkg::KEY_ENTRY, r);
    chk(16'(cfg_mode), 16'h0001);
    i_host.xfer(1'h0, pb + 16'h0001, 8'h00, r);
    chk(16'(r), 16'h0100);
    for (int i = 0; i < 18; i++) begin
      cw(t_off[i], 8'hC3);
      cr(t_off[i], t_exp[i]);
    end
    chk(16'(sel_ldn), 16'h0000);
    cw(icpb_pkg::GOFF_LDN, 8'h02);
    chk(16'(sel_ldn), 16'h0002);
    cw(8'h30, 8'h01);
    chk(16'(dev_active), 16'h0004);
    cr(8'h30, 8'h01);
    cw(icpb_pkg::GOFF_LDN, 8'h01);
    cr(8'h30, 8'h00);
    cr(8'h1E, icpb_pkg::DEVID_DEF[7:0]);
    cw(icpb_pkg::GOFF_LDN, 8'h3F);
    cr(8'h30, 8'hFF);
    cr(8'h1D, icpb_pkg::SUBID_DEF);
    i_ec.xfer(1'h0, 16'h101E, 8'h00, r);
    chk(16'(r), {8'h01, icpb_pkg::DEVID_DEF[7:0]});
    i_ec.xfer(1'h0, 16'h101F, 8'h00, r);
    chk(16'(r), {8'h01, icpb_pkg::DEVID_DEF[15:8]});
    i_ec.xfer(1'h0, 16'h201E, 8'h00, r);
    chk(16'(r), 16'h01FF);
    i_ec.xfer(1'h1, 16'h1007, 8'h03, r);
    chk(16'(sel_ldn), 16'h0003);
    cw(8'h35, 8'h00);
    cw(8'h34, 8'h40);
    chk(port_base, 16'h0040);
    pb = 16'h0040;
    cr(8'h1C, icpb_pkg::REV_DEF);
    i_host.xfer(1'h0, pb, 8'h00, r);
    chk(16'(r), 16'h011C);
    @(posedge clk);
    host_reset <= 1'h1;
    @(posedge clk);
    host_reset <= 1'h0;
    #1;
    chk(16'(cfg_mode), 16'h0000);
    i_host.key(pb, icpb_pkg::KEY_ENTRY, r);
    i_host.key(pb, icpb_pkg::KEY_EXIT, r);
    chk(16'(cfg_mode), 16'h0000);
    cr(8'h1C, 8'hFF);
    i_host.key(pb, icpb_pkg::KEY_ENTRY, r);
    @(posedge clk);
    rst_b <= 1'h0;
    @(posedge clk);
    rst_b <= 1'h1;
    #1;
    chk(16'(cfg_mode), 16'h0000);
    chk(port_base, 16'h002E);
    summarize();
  end
endmodule
`default_nettype wire
